// >>> hw/epi_top.sv
// external pin interrupt unit: two dedicated inputs, 28 pin-change inputs
// assumes a one-cycle register port and a cpu dispatch on the same clock
`timescale 1ns/10ps
`default_nettype none
module epi_top
    import epi_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RSTN,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WR_DATA,
    input  wire logic                WR_STB,
    input  wire logic                RD_STB,
    output logic      [7:0]          RD_DATA,
    input  wire logic                DEDICATED_INPUT_A,
    input  wire logic                DEDICATED_INPUT_B,
    input  wire logic [PC_NUM-1:0]   BANK_INPUTS,
    input  wire logic                GLOBAL_INT_EN,
    input  wire logic [IRQ_NUM-1:0]  VECTOR_ACK,
    output logic      [IRQ_NUM-1:0]  IRQ_REQ
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0]          settle;
        logic [7:0]          sense;
        logic [DED_NUM-1:0]  ded_en;
        logic [DED_NUM-1:0]  ded_pend;
        logic [BANK_NUM-1:0] bank_en;
        logic [BANK_NUM-1:0] bank_pend;
        logic [PC_NUM-1:0]   pc_mask;
        logic [DED_NUM-1:0]  prev_ded;
        logic [PC_NUM-1:0]   prev_pc;
        logic [IRQ_NUM-1:0]  irq;
        logic [7:0]          rdata;
    } epi_state_t;

    epi_state_t st_r;
    epi_state_t st_nxt;

    logic [DED_NUM+PC_NUM-1:0] pins_raw;
    logic [DED_NUM+PC_NUM-1:0] pins_sync;
    logic [DED_NUM-1:0]        ded_cur;
    logic [PC_NUM-1:0]         pc_cur;
    logic [PC_NUM-1:0]         pin_live;
    logic [7:0]                view_sense;
    logic [7:0]                view_ded_en;
    logic [7:0]                view_ded_pend;
    logic [7:0]                view_bank_en;
    logic [7:0]                view_bank_pend;
    logic [7:0]                view_mask0;
    logic [7:0]                view_mask1;
    logic [7:0]                view_mask2;
    logic [7:0]                view_mask3;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // pins read as they stand, whatever drives them
    assign pins_raw = {BANK_INPUTS, DEDICATED_INPUT_B, DEDICATED_INPUT_A};

    // every pin passes two flops first
    epi_sync #(
        .W (DED_NUM + PC_NUM)
    ) u_sync (
        .clk   (SYS_CLK),
        .rst_n (RSTN),
        .din   (pins_raw),
        .dout  (pins_sync)
    );

    assign ded_cur = pins_sync[DED_NUM-1:0];
    assign pc_cur  = pins_sync[DED_NUM+PC_NUM-1:DED_NUM];

    ////////////////////////////////////////////////////////////////////////////
    // per-pin gating: mask bit counts only with its bank enable

    for (genvar g = 0; g < PC_NUM; g++) begin : g_live
        assign pin_live[g] = st_r.pc_mask[g] & st_r.bank_en[g / BANK_W];
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read images, reserved bits zero

    assign view_sense     = {4'h0, st_r.sense[3:0]};
    assign view_ded_en    = {6'h00, st_r.ded_en};
    assign view_ded_pend  = {6'h00, st_r.ded_pend};
    assign view_bank_en   = {4'h0, st_r.bank_en};
    assign view_bank_pend = {4'h0, st_r.bank_pend};
    assign view_mask0     = st_r.pc_mask[7:0];
    assign view_mask1     = st_r.pc_mask[15:8];
    assign view_mask2     = st_r.pc_mask[23:16];
    assign view_mask3     = {4'h0, st_r.pc_mask[27:24]};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [DED_NUM-1:0]  ded_hit;
        logic [DED_NUM-1:0]  ded_lvl;
        logic [DED_NUM-1:0]  ded_clr;
        logic [BANK_NUM-1:0] bank_hit;
        logic [BANK_NUM-1:0] bank_clr;
        logic [DED_NUM-1:0]  rise;
        logic [DED_NUM-1:0]  fall;
        logic [PC_NUM-1:0]   chg;
        epi_sense_t          mode;
        logic                armed;
        armed    = 1'b0;
        ded_hit  = '0;
        ded_lvl  = '0;
        ded_clr  = '0;
        bank_hit = '0;
        bank_clr = '0;
        mode     = SENSE_LOW;
        st_nxt   = st_r;

        // compare with the held sample, so a change while the
        // clock stood still shows at its first edge
        // no edge until the synchroniser holds real pin values, so an
        // idle-high pin gives no false edge after reset
        armed = (st_r.settle == 2'h3);
        rise = ded_cur & ~st_r.prev_ded & {DED_NUM{armed}};
        fall = ~ded_cur & st_r.prev_ded & {DED_NUM{armed}};
        chg  = (pc_cur ^ st_r.prev_pc) & {PC_NUM{armed}};

        st_nxt.settle   = armed ? st_r.settle : st_r.settle + 2'h1;
        st_nxt.prev_ded = ded_cur;
        st_nxt.prev_pc  = pc_cur;

        // dedicated inputs: a at bits 1:0, b at 3:2
        for (int i = 0; i < DED_NUM; i++) begin
            mode = epi_sense_t'(st_r.sense[i*SENSE_W +: SENSE_W]);
            case (mode)
                SENSE_LOW: begin
                    ded_lvl[i] = 1'b1;
                end
                SENSE_ANY: begin
                    ded_hit[i] = rise[i] | fall[i];
                end
                SENSE_FALL: begin
                    ded_hit[i] = fall[i];
                end
                SENSE_RISE: begin
                    ded_hit[i] = rise[i];
                end
                default: begin
                    ded_hit[i] = 1'b0;
                end
            endcase
        end

        // pin changes grouped by eight; mask needs bank enable
        for (int j = 0; j < PC_NUM; j++) begin
            if (chg[j] && pin_live[j]) begin
                bank_hit[j/BANK_W] = 1'b1;
            end
        end

        // register writes
        if (WR_STB) begin
            case (ADDR)
                OFS_DED_SENSE: begin
                    st_nxt.sense = {4'h0, WR_DATA[3:0]};
                end
                OFS_DED_ENABLE: begin
                    st_nxt.ded_en = WR_DATA[DED_NUM-1:0];
                end
                OFS_DED_PENDING: begin
                    ded_clr = WR_DATA[DED_NUM-1:0];
                end
                OFS_BANK_ENABLE: begin
                    st_nxt.bank_en = WR_DATA[BANK_NUM-1:0];
                end
                OFS_BANK_PEND: begin
                    bank_clr = WR_DATA[BANK_NUM-1:0];
                end
                OFS_BANK0_MASK: begin
                    st_nxt.pc_mask[7:0] = WR_DATA;
                end
                OFS_BANK1_MASK: begin
                    st_nxt.pc_mask[15:8] = WR_DATA;
                end
                OFS_BANK2_MASK: begin
                    st_nxt.pc_mask[23:16] = WR_DATA;
                end
                OFS_BANK3_MASK: begin
                    st_nxt.pc_mask[27:24] = WR_DATA[BANK3_W-1:0];
                end
                default: begin
                    st_nxt.sense = st_r.sense;
                end
            endcase
        end

        // vectoring clears too; a new hit wins over any clear
        ded_clr  = ded_clr | VECTOR_ACK[IRQ_DED_B:IRQ_DED_A];
        bank_clr = bank_clr | VECTOR_ACK[IRQ_NUM-1:IRQ_BANK0];
        st_nxt.ded_pend  = (st_r.ded_pend & ~ded_clr) | ded_hit;
        st_nxt.bank_pend = (st_r.bank_pend & ~bank_clr) | bank_hit;
        // level mode holds its pending bit cleared
        st_nxt.ded_pend  = st_nxt.ded_pend & ~ded_lvl;

        // requests to dispatch
        for (int i = 0; i < DED_NUM; i++) begin
            if (ded_lvl[i]) begin
                // level request follows the pin
                st_nxt.irq[i] = ~ded_cur[i] & st_r.ded_en[i] & GLOBAL_INT_EN;
            end else begin
                st_nxt.irq[i] = st_r.ded_pend[i] & st_r.ded_en[i] & GLOBAL_INT_EN;
            end
        end
        for (int b = 0; b < BANK_NUM; b++) begin
            st_nxt.irq[IRQ_BANK0 + b] = st_r.bank_pend[b] & st_r.bank_en[b] & GLOBAL_INT_EN;
        end

        // register reads, unused bits zero
        st_nxt.rdata = 8'h00;
        if (RD_STB) begin
            case (ADDR)
                OFS_DED_SENSE: begin
                    st_nxt.rdata = view_sense;
                end
                OFS_DED_ENABLE: begin
                    st_nxt.rdata = view_ded_en;
                end
                OFS_DED_PENDING: begin
                    st_nxt.rdata = view_ded_pend;
                end
                OFS_BANK_ENABLE: begin
                    st_nxt.rdata = view_bank_en;
                end
                OFS_BANK_PEND: begin
                    st_nxt.rdata = view_bank_pend;
                end
                OFS_BANK0_MASK: begin
                    st_nxt.rdata = view_mask0;
                end
                OFS_BANK1_MASK: begin
                    st_nxt.rdata = view_mask1;
                end
                OFS_BANK2_MASK: begin
                    st_nxt.rdata = view_mask2;
                end
                OFS_BANK3_MASK: begin
                    st_nxt.rdata = view_mask3;
                end
                default: begin
                    st_nxt.rdata = REG_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA = st_r.rdata;
    assign IRQ_REQ = st_r.irq;

endmodule
`default_nettype wire

// >>> inc/epi_pkg.sv
// constants for the external pin interrupt unit
// assumes an 8-bit register port and one 10 MHz clock
package epi_pkg;
    // register offsets
    localparam logic [7:0] OFS_DED_PENDING = 8'h1c;
    localparam logic [7:0] OFS_DED_ENABLE  = 8'h1d;
    localparam logic [7:0] OFS_BANK_ENABLE = 8'h68;
    localparam logic [7:0] OFS_DED_SENSE   = 8'h69;
    localparam logic [7:0] OFS_BANK3_MASK  = 8'h6a;
    localparam logic [7:0] OFS_BANK0_MASK  = 8'h6b;
    localparam logic [7:0] OFS_BANK1_MASK  = 8'h6c;
    localparam logic [7:0] OFS_BANK2_MASK  = 8'h6d;
    localparam logic [7:0] OFS_BANK_PEND   = 8'h1b;
    // field positions and widths
    localparam int SENSE_A_POS  = 0;
    localparam int SENSE_B_POS  = 2;
    localparam int SENSE_W      = 2;
    localparam int DED_NUM      = 2;
    localparam int BANK_NUM     = 4;
    localparam int PC_NUM       = 28;
    localparam int BANK_W       = 8;
    localparam int BANK3_W      = 4;
    localparam int IRQ_NUM      = 6;
    localparam int IRQ_DED_A    = 0;
    localparam int IRQ_DED_B    = 1;
    localparam int IRQ_BANK0    = 2;
    // reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;
    // sense codes
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epi_sense_t;
endpackage

// >>> hw/epi_sync.sv
// two-stage synchroniser for a group of pins
// assumes the pins are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module epi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } epi_sync_st_t;

    epi_sync_st_t st_r;
    epi_sync_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;

endmodule
`default_nettype wire

// >>> verif/epi_properties.sv
// assertion checker for the external pin interrupt unit
// assumes binding to epi_top, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module epi_properties
    import epi_pkg::*;
(
    input wire logic               SYS_CLK,
    input wire logic               RSTN,
    input wire logic [7:0]         ADDR,
    input wire logic               RD_STB,
    input wire logic [7:0]         RD_DATA,
    input wire logic               GLOBAL_INT_EN,
    input wire logic [IRQ_NUM-1:0] IRQ_REQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
        else $error("read data outside slot");
    AST_EN_RSV: assert property ($past(RD_STB) && $past(ADDR) == OFS_DED_ENABLE |-> RD_DATA[7:2] == 6'h00)
        else $error("enable reserved bits set");
    AST_SENSE_RSV: assert property ($past(RD_STB) && $past(ADDR) == OFS_DED_SENSE |-> RD_DATA[7:4] == 4'h0)
        else $error("sense reserved bits set");
    AST_BEN_RSV: assert property ($past(RD_STB) && $past(ADDR) == OFS_BANK_ENABLE |-> RD_DATA[7:4] == 4'h0)
        else $error("bank enable reserved bits set");
    AST_BPEND_RSV: assert property ($past(RD_STB) && $past(ADDR) == OFS_BANK_PEND |-> RD_DATA[7:4] == 4'h0)
        else $error("bank pending reserved bits set");
    AST_MASK3_RSV: assert property ($past(RD_STB) && $past(ADDR) == OFS_BANK3_MASK |-> RD_DATA[7:4] == 4'h0)
        else $error("bank3 mask reserved bits set");
    AST_NO_GIE: assert property (!GLOBAL_INT_EN [*2] |-> IRQ_REQ == '0)
        else $error("request without global enable");
    AST_RESET: assert property ($rose(RSTN) |-> IRQ_REQ == '0 && RD_DATA == 8'h00)
        else $error("outputs not clear after reset");
endmodule
`default_nettype wire

// >>> verif/epi_cpu_model.sv
// cpu dispatch model: vectors the lowest pending request
// assumes the same clock as the unit; ack_en lets it answer or stall
`timescale 1ns/10ps
`default_nettype none
module epi_cpu_model
    import epi_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ack_en,
    input  wire logic [IRQ_NUM-1:0] irq_req,
    output logic      [IRQ_NUM-1:0] vector_ack
);
    logic [1:0] hold_r = 2'd0;
    initial vector_ack = '0;
    always @(posedge clk) begin
        vector_ack <= '0;
        if (!rst_n) begin
            hold_r <= 2'd0;
        end else if (hold_r != 2'd0) begin
            hold_r <= hold_r - 2'd1;
        end else if (ack_en && irq_req != '0) begin
            vector_ack <= irq_req & (~irq_req + 1'b1);
            hold_r <= 2'd3;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the external pin interrupt unit
// assumes epi_top, epi_cpu_model and epi_properties compiled first
`timescale 1ns/10ps
`default_nettype none
module tb
    import epi_pkg::*;
;
    logic               SYS_CLK = 1'b0;
    logic               RSTN = 1'b0;
    logic [7:0]         ADDR = 8'h00;
    logic [7:0]         WR_DATA = 8'h00;
    logic               WR_STB = 1'b0;
    logic               RD_STB = 1'b0;
    logic [7:0]         RD_DATA;
    logic               DEDICATED_INPUT_A = 1'b1;
    logic               DEDICATED_INPUT_B = 1'b1;
    logic [PC_NUM-1:0]  BANK_INPUTS = '0;
    logic               GLOBAL_INT_EN = 1'b0;
    logic [IRQ_NUM-1:0] VECTOR_ACK;
    logic [IRQ_NUM-1:0] IRQ_REQ;
    logic               ack_en = 1'b0;
    int                 miscompares = 0;
    int                 num_checks = 0;
    localparam logic [7:0] OFS [10] = '{OFS_DED_ENABLE, OFS_BANK_ENABLE, OFS_DED_SENSE, OFS_BANK3_MASK,
        OFS_BANK0_MASK, OFS_BANK1_MASK, OFS_BANK2_MASK, OFS_BANK_PEND, OFS_DED_PENDING, 8'h55};
    localparam logic [7:0] MSK [10] = '{8'h03, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    always #50 SYS_CLK = ~SYS_CLK;
    epi_top dut_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
        .RD_STB(RD_STB), .RD_DATA(RD_DATA), .DEDICATED_INPUT_A(DEDICATED_INPUT_A),
        .DEDICATED_INPUT_B(DEDICATED_INPUT_B), .BANK_INPUTS(BANK_INPUTS), .GLOBAL_INT_EN(GLOBAL_INT_EN),
        .VECTOR_ACK(VECTOR_ACK), .IRQ_REQ(IRQ_REQ));
    epi_cpu_model cpu_u (.clk(SYS_CLK), .rst_n(RSTN), .ack_en(ack_en), .irq_req(IRQ_REQ),
        .vector_ack(VECTOR_ACK));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_STB <= 1'b1;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge SYS_CLK);
        RD_STB <= 1'b0;
        #1 chk(RD_DATA, e);
    endtask
    task automatic pin(input int k, input logic v, input logic ei, input logic ep);
        @(posedge SYS_CLK);
        if (k == 0) DEDICATED_INPUT_A <= v;
        else DEDICATED_INPUT_B <= v;
        repeat (6) @(posedge SYS_CLK);
        #1 chk(8'(IRQ_REQ[k]), 8'(ei));
        rd(OFS_DED_PENDING, 8'(ep) << k);
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge SYS_CLK);
        miscompares++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] pm;
        logic [31:0] r;
        int          p;
        int          b;
        logic        hit;
        r = $urandom(32'h858f430e);
        repeat (8) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 10; i++) rd(OFS[i], 8'h00);
        for (int i = 0; i < 10; i++) begin
            r = $urandom;
            wr(OFS[i], r[7:0]);
            rd(OFS[i], r[7:0] & MSK[i]);
        end
        @(posedge SYS_CLK);
        GLOBAL_INT_EN <= 1'b1;
        wr(OFS_DED_ENABLE, 8'h03);
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                wr(OFS_DED_SENSE, 8'(m << (2 * k)));
                wr(OFS_DED_PENDING, 8'h03);
                pin(k, 1'b0, m != 3, m == 1 || m == 2);
                wr(OFS_DED_PENDING, 8'h03);
                pin(k, 1'b1, m[0], m[0]);
            end
        end
        wr(OFS_DED_ENABLE, 8'h00);
        wr(OFS_DED_PENDING, 8'h03);
        for (int i = 0; i < 24; i++) begin
            pm = $urandom;
            r = $urandom;
            p = $urandom_range(27, 0);
            if (i < 8) begin
                pm = '1;
                r = (i < 4) ? 32'h2f : 32'h3f;
                p = (i % 4) * 8 + 3;
            end
            b = p / 8;
            wr(OFS_BANK0_MASK, pm[7:0]);
            wr(OFS_BANK1_MASK, pm[15:8]);
            wr(OFS_BANK2_MASK, pm[23:16]);
            wr(OFS_BANK3_MASK, {4'h0, pm[27:24]});
            wr(OFS_BANK_ENABLE, {4'h0, r[3:0]});
            wr(OFS_BANK_PEND, 8'h0f);
            ack_en <= r[4];
            GLOBAL_INT_EN <= r[5];
            hit = pm[p] && r[b];
            @(posedge SYS_CLK);
            BANK_INPUTS[p] <= ~BANK_INPUTS[p];
            repeat (10) @(posedge SYS_CLK);
            #1 chk(8'(IRQ_REQ[b + 2]), 8'(hit && r[5] && !r[4]));
            rd(OFS_BANK_PEND, 8'(hit && !(r[4] && r[5])) << b);
        end
        stop_test();
    end
endmodule
bind epi_top epi_properties chk_u (.*);
`default_nettype wire
